//--- rtl/hbd_drive_ctrl.sv
`timescale 1ns/1ps
`include "hbd_cfg.svh"

// How it works
// - Gate supply below off level puts that channel in the safe state.
// - Gate supply back at on level resumes driving from current inputs.
// - Safe state: sink switch on, source switch off, output pulled low.
// - Safe state held through power-up and power-down, whatever the inputs.
// - Missing logic supply holds safe state until the supply returns.
// - Input decode applies only when no safe condition is active.
// - Shutdown low drives both outputs low.
// - Shutdown high, brake low: channel A low, channel B high.
// - Both high: single command follows, both or none give both low.
// - Input pulses shorter than the deglitch time are ignored.
// - Lost link watchdog forces safe state until heartbeats return.
// - Over-temperature forces safe state until cooled past hysteresis.
// - Standby pattern held past the entry time enters standby.
// - Standby keeps outputs forced low through the awake delay, and flags low-power operation until the awake delay starts.
// - Inputs leaving the pattern alone do not end standby.
// - Exit: non-pattern past filter, then pattern within the wake window.
// - On leaving the pattern after wake, outputs enable after awake delay.
module hbd_drive_ctrl #(
  parameter int CLK_MHZ = `HBD_CLK_MHZ,
  parameter int DEGLITCH_CYC = hbd_pkg::hbd_ns_to_cyc(`HBD_DEGLITCH_NS, CLK_MHZ),
  parameter int STBY_ENTRY_CYC = hbd_pkg::hbd_ns_to_cyc(`HBD_STBY_ENTRY_NS, CLK_MHZ),
  parameter int STBY_FILT_CYC = hbd_pkg::hbd_ns_to_cyc(`HBD_STBY_FILT_NS, CLK_MHZ),
  parameter int WAKE_MIN_CYC = hbd_pkg::hbd_ns_to_cyc(`HBD_WAKE_MIN_NS, CLK_MHZ),
  parameter int AWAKE_CYC = hbd_pkg::hbd_ns_to_cyc(`HBD_AWAKE_NS, CLK_MHZ),
  parameter int WDOG_CYC = hbd_pkg::hbd_ns_to_cyc(`HBD_WDOG_NS, CLK_MHZ)
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic shutdown_n,
  input wire logic brake_n,
  input wire logic chan_a_cmd,
  input wire logic chan_b_cmd,
  input wire logic gate_supply_below_off_a,
  input wire logic gate_supply_at_on_a,
  input wire logic gate_supply_below_off_b,
  input wire logic gate_supply_at_on_b,
  input wire logic logic_supply_ok,
  input wire logic link_heartbeat,
  input wire logic overtemp_level,
  input wire logic overtemp_cleared,
  output logic drive_out_a,
  output logic drive_out_b,
  output logic sink_switch_a,
  output logic source_switch_a,
  output logic sink_switch_b,
  output logic source_switch_b,
  output logic safe_state_a,
  output logic safe_state_b,
  output logic standby,
  output logic low_power
);

  localparam int CW = `HBD_CNT_W;
  localparam int WW = `HBD_WDOG_CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  generate
    if (STBY_ENTRY_CYC >= (1 << CW) || AWAKE_CYC >= (1 << CW)) begin : g_bad_cw
      $error("hbd_drive_ctrl: timer counts exceed counter width");
    end
    if (WAKE_MIN_CYC >= STBY_ENTRY_CYC || STBY_FILT_CYC < 1) begin : g_bad_win
      $error("hbd_drive_ctrl: wake window must end before standby entry time");
    end
    if (WDOG_CYC < 2 || WDOG_CYC >= (1 << WW)) begin : g_bad_wd
      $error("hbd_drive_ctrl: watchdog count does not fit");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    hbd_pkg::hbd_mode_t mode;
    logic [CW-1:0] cnt;
    logic [WW-1:0] wdog_cnt;
    logic link_lost;
    logic uv_a;
    logic uv_b;
    logic ot;
    logic drive_a;
    logic drive_b;
    logic sink_a;
    logic source_a;
    logic sink_b;
    logic source_b;
    logic safe_a;
    logic safe_b;
    logic standby;
    logic low_power;
  } hbd_state_t;

  hbd_state_t st_r;
  hbd_state_t st_nxt;

  logic [`HBD_IN_W-1:0] in_raw;
  logic [`HBD_IN_W-1:0] in_clean;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Truth table of the four control inputs, {a, b}
  function automatic logic [1:0] hbd_decode(input logic [`HBD_IN_W-1:0] v);
    logic [1:0] d;
    d = 2'h0;
    if (!v[`HBD_IN_SD]) begin
      d = 2'h0;
    end else if (!v[`HBD_IN_BRAKE]) begin
      d = 2'h1;
    end else if (v[`HBD_IN_A] ^ v[`HBD_IN_B]) begin
      d = {v[`HBD_IN_A], v[`HBD_IN_B]};
    end else begin
      d = 2'h0;
    end
    return d;
  endfunction : hbd_decode

  // Count reached its terminal value (count starts at zero)
  function automatic logic hbd_done(input logic [CW-1:0] c, input int term);
    return c >= CW'(term - 1);
  endfunction : hbd_done

  // Supply flag with hysteresis: falling below off wins over on
  function automatic logic hbd_hyst(input logic cur, input logic set, input logic clr);
    logic v;
    v = cur;
    if (set) begin
      v = 1'b1;
    end else if (clr) begin
      v = 1'b0;
    end
    return v;
  endfunction : hbd_hyst

  ////////////////////////////////////////////////////////////////////////////
  // Input filter

  assign in_raw = {shutdown_n, brake_n, chan_a_cmd, chan_b_cmd};

  hbd_deglitch #(
    .N(`HBD_IN_W),
    .STABLE_CYC(DEGLITCH_CYC),
    .CW(`HBD_DG_CNT_W)
  ) u_deglitch (
    .clock(clock),
    .reset(reset),
    .raw(in_raw),
    .clean(in_clean)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic pat;
    logic common_safe;
    logic [1:0] dec;
    pat = 1'b0;
    common_safe = 1'b1;
    dec = 2'h0;
    st_nxt = st_r;
    pat = (in_clean == `HBD_STBY_PATTERN);

    // Supply and temperature flags
    st_nxt.uv_a = hbd_hyst(st_r.uv_a, gate_supply_below_off_a,
                           gate_supply_at_on_a);
    st_nxt.uv_b = hbd_hyst(st_r.uv_b, gate_supply_below_off_b,
                           gate_supply_at_on_b);
    st_nxt.ot = hbd_hyst(st_r.ot, overtemp_level, overtemp_cleared);

    // Watchdog: the logic side counts as silent without its supply
    if (link_heartbeat && logic_supply_ok) begin
      st_nxt.wdog_cnt = '0;
      st_nxt.link_lost = 1'b0;
    end else if (st_r.wdog_cnt == WW'(WDOG_CYC - 1)) begin
      st_nxt.link_lost = 1'b1;
    end else begin
      st_nxt.wdog_cnt = st_r.wdog_cnt + WW'(1);
    end

    // Standby sequencing, one shared timer
    case (st_r.mode)
      hbd_pkg::hbd_mode_run: begin
        if (!pat) begin
          st_nxt.cnt = '0;
        end else if (hbd_done(st_r.cnt, STBY_ENTRY_CYC)) begin
          st_nxt.mode = hbd_pkg::hbd_mode_stby;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + CW'(1);
        end
      end
      hbd_pkg::hbd_mode_stby: begin
        // Leaving the pattern only arms the exit filter
        if (pat) begin
          st_nxt.cnt = '0;
        end else if (hbd_done(st_r.cnt, STBY_FILT_CYC)) begin
          st_nxt.mode = hbd_pkg::hbd_mode_stby_armed;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + CW'(1);
        end
      end
      hbd_pkg::hbd_mode_stby_armed: begin
        if (pat) begin
          st_nxt.mode = hbd_pkg::hbd_mode_stby_wake;
          st_nxt.cnt = '0;
        end
      end
      hbd_pkg::hbd_mode_stby_wake: begin
        if (pat) begin
          if (hbd_done(st_r.cnt, STBY_ENTRY_CYC)) begin
            // Held too long: still a standby request
            st_nxt.mode = hbd_pkg::hbd_mode_stby;
            st_nxt.cnt = '0;
          end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
          end
        end else if (st_r.cnt >= CW'(WAKE_MIN_CYC)) begin
          st_nxt.mode = hbd_pkg::hbd_mode_awaking;
          st_nxt.cnt = '0;
        end else begin
          // Too short a wake pulse; wait for another
          st_nxt.mode = hbd_pkg::hbd_mode_stby_armed;
          st_nxt.cnt = '0;
        end
      end
      hbd_pkg::hbd_mode_awaking: begin
        if (hbd_done(st_r.cnt, AWAKE_CYC)) begin
          st_nxt.mode = hbd_pkg::hbd_mode_run;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + CW'(1);
        end
      end
      default: begin
        st_nxt.mode = hbd_pkg::hbd_mode_run;
        st_nxt.cnt = '0;
      end
    endcase

    // Output stage, from the next flags so outputs react one cycle sooner
    common_safe = !logic_supply_ok || st_nxt.link_lost || st_nxt.ot ||
                  (st_nxt.mode != hbd_pkg::hbd_mode_run);
    st_nxt.safe_a = common_safe || st_nxt.uv_a;
    st_nxt.safe_b = common_safe || st_nxt.uv_b;
    dec = hbd_decode(in_clean);
    st_nxt.drive_a = !st_nxt.safe_a && dec[1];
    st_nxt.drive_b = !st_nxt.safe_b && dec[0];
    // Sink on whenever not sourcing; safe state never sources
    st_nxt.source_a = st_nxt.drive_a;
    st_nxt.sink_a = !st_nxt.drive_a;
    st_nxt.source_b = st_nxt.drive_b;
    st_nxt.sink_b = !st_nxt.drive_b;
    st_nxt.standby = (st_nxt.mode != hbd_pkg::hbd_mode_run);
    st_nxt.low_power = (st_nxt.mode == hbd_pkg::hbd_mode_stby) ||
                       (st_nxt.mode == hbd_pkg::hbd_mode_stby_armed) ||
                       (st_nxt.mode == hbd_pkg::hbd_mode_stby_wake);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r.mode <= hbd_pkg::hbd_mode_run;
      st_r.cnt <= '0;
      st_r.wdog_cnt <= '0;
      st_r.link_lost <= `HBD_LINK_LOST_RST;
      st_r.uv_a <= `HBD_UV_RST;
      st_r.uv_b <= `HBD_UV_RST;
      st_r.ot <= `HBD_OT_RST;
      st_r.drive_a <= 1'b0;
      st_r.drive_b <= 1'b0;
      st_r.sink_a <= 1'b1;
      st_r.source_a <= 1'b0;
      st_r.sink_b <= 1'b1;
      st_r.source_b <= 1'b0;
      st_r.safe_a <= 1'b1;
      st_r.safe_b <= 1'b1;
      st_r.standby <= 1'b0;
      st_r.low_power <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign drive_out_a = st_r.drive_a;
  assign drive_out_b = st_r.drive_b;
  assign sink_switch_a = st_r.sink_a;
  assign source_switch_a = st_r.source_a;
  assign sink_switch_b = st_r.sink_b;
  assign source_switch_b = st_r.source_b;
  assign safe_state_a = st_r.safe_a;
  assign safe_state_b = st_r.safe_b;
  assign standby = st_r.standby;
  assign low_power = st_r.low_power;

endmodule : hbd_drive_ctrl

//--- rtl/hbd_cfg.svh
`ifndef HBD_CFG_SVH
`define HBD_CFG_SVH

// Internal clock rate
`define HBD_CLK_MHZ 200

// Timings in ns, as printed (typical figures)
`define HBD_DEGLITCH_NS 20
`define HBD_STBY_ENTRY_NS 280000
`define HBD_STBY_FILT_NS 280
`define HBD_WAKE_MIN_NS 20000
`define HBD_AWAKE_NS 140000
`define HBD_WDOG_NS 1000

// Counter widths
`define HBD_CNT_W 18
`define HBD_DG_CNT_W 4
`define HBD_WDOG_CNT_W 10

// Filtered input vector layout
`define HBD_IN_W 4
`define HBD_IN_SD 3
`define HBD_IN_BRAKE 2
`define HBD_IN_A 1
`define HBD_IN_B 0

// Shutdown low, brake and both commands high
`define HBD_STBY_PATTERN 4'h7

// Reset values
`define HBD_IN_RST 4'h0
`define HBD_UV_RST 1'b1
`define HBD_LINK_LOST_RST 1'b1
`define HBD_OT_RST 1'b0

`endif

//--- rtl/hbd_pkg.sv
package hbd_pkg;

  typedef enum logic [2:0] {
    hbd_mode_run,
    hbd_mode_stby,
    hbd_mode_stby_armed,
    hbd_mode_stby_wake,
    hbd_mode_awaking
  } hbd_mode_t;

  // Least time in ns to whole cycles, rounded up, at least one
  function automatic int hbd_ns_to_cyc(input int ns, input int mhz);
    int c;
    c = (ns * mhz + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : hbd_ns_to_cyc

endpackage : hbd_pkg

//--- rtl/hbd_deglitch.sv
`timescale 1ns/1ps
`include "hbd_cfg.svh"

module hbd_deglitch #(
  parameter int N = `HBD_IN_W,
  parameter int STABLE_CYC = 4,
  parameter int CW = `HBD_DG_CNT_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] clean
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] clean;
    logic [N-1:0][CW-1:0] cnt;
  } hbd_dg_state_t;

  hbd_dg_state_t st_r;
  hbd_dg_state_t st_nxt;

  generate
    if (STABLE_CYC < 1 || STABLE_CYC >= (1 << CW)) begin : g_bad
      $error("hbd_deglitch: STABLE_CYC does not fit CW");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    for (int i = 0; i < N; i++) begin
      // A change must persist STABLE_CYC samples before it is taken
      if (st_r.s2[i] == st_r.clean[i]) begin
        st_nxt.cnt[i] = '0;
      end else if (st_r.cnt[i] == CW'(STABLE_CYC - 1)) begin
        st_nxt.clean[i] = st_r.s2[i];
        st_nxt.cnt[i] = '0;
      end else begin
        st_nxt.cnt[i] = st_r.cnt[i] + CW'(1);
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clean = st_r.clean;

endmodule : hbd_deglitch

//--- sim/hbd_pwm_model.sv
`timescale 1ns/1ps
module hbd_pwm_model (
  input wire logic clock,
  input wire logic [3:0] pattern,
  input wire logic hb_en,
  output logic shutdown_n,
  output logic brake_n,
  output logic chan_a_cmd,
  output logic chan_b_cmd,
  output logic link_heartbeat
);
  logic [1:0] hb_cnt_r = 2'h0;
  //////////////////////////////
  // Bench moves the pattern on the falling edge; following it at once avoids a race there
  assign {shutdown_n, brake_n, chan_a_cmd, chan_b_cmd} = pattern;
  always @(negedge clock) begin
    hb_cnt_r <= hb_cnt_r + 2'h1;
    // Strobe every 4 cycles, well inside the watchdog span
    link_heartbeat <= hb_en && (hb_cnt_r == 2'h0);
  end
endmodule : hbd_pwm_model

//--- sim/hbd_drive_ctrl_props.sv
`timescale 1ns/1ps
module hbd_drive_ctrl_chk #(
  parameter int WDOG_CYC = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic shutdown_n,
  input wire logic brake_n,
  input wire logic chan_a_cmd,
  input wire logic chan_b_cmd,
  input wire logic gate_supply_below_off_a,
  input wire logic gate_supply_below_off_b,
  input wire logic gate_supply_at_on_b,
  input wire logic logic_supply_ok,
  input wire logic link_heartbeat,
  input wire logic overtemp_level,
  input wire logic drive_out_a,
  input wire logic drive_out_b,
  input wire logic sink_switch_a,
  input wire logic source_switch_a,
  input wire logic sink_switch_b,
  input wire logic source_switch_b,
  input wire logic safe_state_a,
  input wire logic safe_state_b,
  input wire logic standby,
  input wire logic low_power
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] quiet_r;
  // Margin of three cycles over the timeout covers the status pipeline
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      quiet_r <= 8'h00;
    end else if (link_heartbeat && logic_supply_ok) begin
      quiet_r <= 8'h00;
    end else if (quiet_r != 8'hFF) begin
      quiet_r <= quiet_r + 8'h01;
    end
  end
  //////////////////////////////
  sequence s_sd_low;
    !shutdown_n [*8];
  endsequence
  sequence s_brake;
    (shutdown_n && !brake_n && !safe_state_b && !standby) [*8];
  endsequence
  sequence s_uv_b;
    gate_supply_below_off_b ##1 !gate_supply_at_on_b [*3];
  endsequence
  //////////////////////////////
  chk_safe_a_low: assert property (safe_state_a |-> !drive_out_a && sink_switch_a && !source_switch_a)
    else $error("safe channel a not pulled low");
  chk_safe_b_low: assert property (safe_state_b |-> !drive_out_b && sink_switch_b && !source_switch_b)
    else $error("safe channel b not pulled low");
  chk_uv_a_safe: assert property (gate_supply_below_off_a |=> safe_state_a)
    else $error("undervoltage a not safe");
  chk_uv_b_hold: assert property (s_uv_b |=> safe_state_b)
    else $error("channel b left safe below on level");
  chk_supply_loss: assert property (!logic_supply_ok |=> safe_state_a && safe_state_b)
    else $error("logic supply loss not safe");
  chk_over_temp: assert property (overtemp_level |=> safe_state_a && safe_state_b)
    else $error("over-temperature not safe");
  chk_link_lost: assert property (quiet_r >= WDOG_CYC + 3 |-> safe_state_a && safe_state_b)
    else $error("lost link not safe");
  chk_shutdown_low: assert property (s_sd_low |=> !drive_out_a && !drive_out_b)
    else $error("shutdown did not drive low");
  chk_brake_b: assert property (s_brake |=> drive_out_b || safe_state_b || standby)
    else $error("brake did not drive b high");
  chk_no_overlap: assert property (!(drive_out_a && drive_out_b))
    else $error("both outputs high");
  chk_stage_match: assert property (source_switch_a == drive_out_a && sink_switch_a != drive_out_a && source_switch_b == drive_out_b && sink_switch_b != drive_out_b)
    else $error("output stage switches disagree with drive");
  chk_standby_off: assert property (standby || low_power |-> standby && !drive_out_a && !drive_out_b)
    else $error("standby outputs not low");
  chk_entry_pattern: assert property ($rose(standby) |-> $past(!shutdown_n && brake_n && chan_a_cmd && chan_b_cmd, 10))
    else $error("standby entered without pattern");
endmodule : hbd_drive_ctrl_chk

bind hbd_drive_ctrl hbd_drive_ctrl_chk #(.WDOG_CYC(WDOG_CYC)) chk (.*);

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int WDOG = 8;
  logic clock, reset, hb_en;
  logic [3:0] pattern, p;
  logic [31:0] r;
  logic shutdown_n, brake_n, chan_a_cmd, chan_b_cmd, link_heartbeat;
  logic gate_supply_below_off_a, gate_supply_at_on_a, gate_supply_below_off_b, gate_supply_at_on_b;
  logic logic_supply_ok, overtemp_level, overtemp_cleared;
  logic drive_out_a, drive_out_b, sink_switch_a, source_switch_a, sink_switch_b, source_switch_b;
  logic safe_state_a, safe_state_b, standby, low_power;
  logic [11:0] note_q[$];
  event obs_ev;
  int miscompares = 0;
  int check_count = 0;
  integer seed = 48;
  hbd_drive_ctrl #(.STBY_ENTRY_CYC(60), .STBY_FILT_CYC(5), .WAKE_MIN_CYC(10), .AWAKE_CYC(20),
    .WDOG_CYC(WDOG)) uut (.*);
  hbd_pwm_model pwm (.*);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  //////////////////////////////
  function automatic logic [1:0] decode(input logic [3:0] v);
    if (!v[3]) return 2'h0;
    if (!v[2]) return 2'h1;
    return {v[1] & !v[0], v[0] & !v[1]};
  endfunction : decode
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic compare_out(input logic [5:0] got, input logic [5:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : compare_out
  // Notes {mask, expected} for outputs {a, b, safe a, safe b, standby, low power}
  task automatic note(input logic [5:0] mask, input logic [5:0] exp, input int cyc);
    repeat (cyc) @(negedge clock);
    note_q.push_back({mask, exp});
    ->obs_ev;
  endtask : note
  task automatic wait_standby(input logic lvl);
    int n;
    n = 0;
    while (standby !== lvl && n < 300) begin
      @(negedge clock);
      n++;
    end
    if (n == 300) begin
      miscompares++;
      $display("mismatch at %0t standby %0h expected %0h", $time, standby, lvl);
      wrap_up();
    end
  endtask : wait_standby
  always @(obs_ev) begin : watch
    logic [11:0] n;
    n = note_q.pop_front();
    compare_out({drive_out_a, drive_out_b, safe_state_a, safe_state_b, standby, low_power}
      & n[11:6], n[5:0] & n[11:6]);
  end
  //////////////////////////////
  initial begin
    {pattern, hb_en, logic_supply_ok, overtemp_level, overtemp_cleared} = 8'h0D;
    {gate_supply_below_off_a, gate_supply_at_on_a, gate_supply_below_off_b, gate_supply_at_on_b} = 4'h5;
    reset = 1'b1;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      p = (i < 16) ? i[3:0] : r[3:0];
      pattern = p;
      note(6'h3F, {decode(p), 4'h0}, 10);
    end
    // Three-cycle pulses on each input, the longest that must vanish
    pattern = 4'hE;
    note(6'h3F, 6'h20, 10);
    for (int k = 0; k < 4; k++) begin
      pattern = 4'hE ^ (4'h1 << k);
      repeat (3) @(negedge clock);
      pattern = 4'hE;
      // A pulse let through would show within these cycles
      repeat (8) note(6'h3F, 6'h20, 1);
    end
    for (int ch = 0; ch < 2; ch++) begin
      pattern = ch ? 4'hD : 4'hE;
      note(6'h3F, ch ? 6'h10 : 6'h20, 10);
      {gate_supply_below_off_a, gate_supply_at_on_a, gate_supply_below_off_b, gate_supply_at_on_b} = ch ? 4'h6 : 4'h9;
      note(6'h3F, ch ? 6'h04 : 6'h08, 3);
      {gate_supply_below_off_a, gate_supply_at_on_a, gate_supply_below_off_b, gate_supply_at_on_b} = ch ? 4'h4 : 4'h1;
      note(6'h3F, ch ? 6'h04 : 6'h08, 5);
      {gate_supply_below_off_a, gate_supply_at_on_a, gate_supply_below_off_b, gate_supply_at_on_b} = 4'h5;
      note(6'h3F, ch ? 6'h10 : 6'h20, 4);
    end
    for (int f = 0; f < 3; f++) begin
      {logic_supply_ok, hb_en, overtemp_level, overtemp_cleared} = {f != 0, f != 1, f == 2, f != 2};
      note(6'h3F, 6'h0C, 20);
      overtemp_level = 1'b0;
      note(6'h3F, 6'h0C, 2);
      {logic_supply_ok, hb_en, overtemp_cleared} = 3'h7;
      note(6'h3F, 6'h10, 10);
    end
    pattern = 4'h7;
    wait_standby(1'b1);
    note(6'h33, 6'h03, 1);
    pattern = 4'hE;
    note(6'h33, 6'h03, 20);
    // Too short a wake pulse must leave standby in place
    pattern = 4'h7;
    repeat (4) @(negedge clock);
    pattern = 4'hE;
    note(6'h33, 6'h03, 12);
    pattern = 4'h7;
    repeat (30) @(negedge clock);
    pattern = 4'hE;
    note(6'h33, 6'h02, 12);
    wait_standby(1'b0);
    note(6'h3F, 6'h20, 2);
    reset = 1'b1;
    note(6'h3F, 6'h0C, 2);
    reset = 1'b0;
    note(6'h33, 6'h00, 1);
    note(6'h3F, 6'h20, 11);
    wrap_up();
  end
endmodule : testbench
